// >>> design/sacr_regs.vh
// Register offsets, field positions, reset values and timing counts of the sensor register bank
`ifndef SACR_REGS_VH
`define SACR_REGS_VH
`define SACR_ADDR_OSC 8'h30
`define SACR_ADDR_PADOUT 8'h40
`define SACR_ADDR_PADIN 8'h41
`define SACR_ADDR_TIMEOUT 8'h42
`define SACR_ADDR_EXTADDR 8'h43
`define SACR_ADDR_RES_LO 8'h50
`define SACR_ADDR_RES_HI 8'h51
`define SACR_ADDR_CONV 8'h52
`define SACR_ADDR_BIAS 8'h53
`define SACR_ADDR_RATE 8'h54
`define SACR_ADDR_GAIN 8'h55
`define SACR_ADDR_OFFS 8'h56
`define SACR_ADDR_MUX 8'h57
`define SACR_ADDR_MODE 8'h70
`define SACR_RST_OSC 8'h01
`define SACR_RST_PADOUT 8'hF0
`define SACR_RST_TIMEOUT 8'h00
`define SACR_RST_EXTADDR 8'h00
`define SACR_RST_CONV 8'h28
`define SACR_RST_BIAS 8'hF0
`define SACR_RST_RATE 8'h00
`define SACR_RST_GAIN 8'h0C
`define SACR_RST_OFFS 8'h00
`define SACR_RST_MUX 8'h00
`define SACR_RST_MODE 8'h84
`define SACR_UNLOCK_CODE 8'h96
`define SACR_OSC_EN_BIT 0
`define SACR_PAD1_DIR_BIT 5
`define SACR_PAD0_DIR_BIT 4
`define SACR_PAD1_OUT_BIT 1
`define SACR_PAD0_OUT_BIT 0
`define SACR_TIMEOUT_BIT 5
`define SACR_START_BIT 7
`define SACR_CONT_BIT 1
`define SACR_DEF_BIT 6
`define SACR_BUSY_BIT 7
`define SACR_FORCE_ON_BIT 3
`define SACR_FORCE_OFF_BIT 2
`define SACR_REF_OUT_BIT 1
`define SACR_EXT_REF_BIT 0
`define SACR_DEF_BIAS 8'hFF
`define SACR_DEF_RATE 8'h00
`define SACR_DEF_GAIN 8'h0C
`define SACR_DEF_OFFS 8'h00
`define SACR_SAMPLE_NS 320
`define SACR_CLK_NS 40
`define SACR_SAMPLE_CYC ((`SACR_SAMPLE_NS + `SACR_CLK_NS - 1) / `SACR_CLK_NS)
`endif

// >>> design/sacr_sensor_regs.v
// Register bank and conversion sequencer of the sensor acquisition front end
// Functional notes
// [RULE1] Oscillator enable bit 0, resets to one, cleared for low power.
// [RULE2] Pad direction bits 5 and 4: one is output, zero input; reset output.
// [RULE3] Pad one drives its value only when output and external reference off.
// [RULE4] Pad zero drives its value only when output and reference output off.
// [RULE5] Timeout enable bit 5 is write-only and resets disabled.
// [RULE6] Writing exactly 0x96 makes the two low slave address bits follow the pads.
// [RULE7] Result readable as low byte then high byte, both read-only.
// [RULE8] Writing one to conversion bit 7 starts a conversion.
// [RULE9] Bits 6..5 give two to that power elementary conversions; reset 01.
// [RULE10] Input polarity swaps between successive elementary conversions.
// [RULE11] Bits 4..2 give oversampling two to three plus field; reset 010.
// [RULE12] Bit 1 selects continuous mode, repeating without new start.
// [RULE13] Converter bias bits 7..6 and amplifier bias bits 5..4 reset to 11.
// [RULE14] Bits 7..6 of the rate register select sampling frequency; reset 00.
// [RULE15] Writing one to bit 6 of the mux register loads defaults and starts.
// [RULE16] Bits 5..1 of the mux register select input channel configuration.
// [RULE17] Bit 0 of the mux register picks supply (0) or reference (1).
// [RULE18] Reference chop field forces 0 or 1, or toggles per or every second conversion.
// [RULE19] Mode bit 3 forces the charge pump on and beats force-off.
// [RULE20] Mode bit 2 forces the charge pump off and resets to one.
// [RULE21] Mode bit 1 routes the reference out on pad zero.
// [RULE22] Mode bit 0 takes an external reference from pad one.
// [RULE23] Bias code 00 quarter, 01 half, 11 full bias.
// [RULE24] Four enable bits power the three amplifier stages and the converter.
// [RULE25] Software writes reserved bits with their reset values.
// [RULE26] All registers are reached by eight-bit address over the two-wire slave.
// [RULE27] Busy flag bit 7 of the mux register is one while converting.
// [RULE28] Pad input register returns the current pad levels in bits 1 and 0.
// [RULE29] Gain and offset fields pass unchanged to the analog front end.
`timescale 1ns/100ps
`default_nettype none
`include "sacr_regs.vh"
module sacr_sensor_regs #(
	parameter SAMPLE_CYC = `SACR_SAMPLE_CYC
) (
	input wire clk,
	input wire rst,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire pad0_i,
	input wire pad1_i,
	output wire pad0_o,
	output wire pad0_oe,
	output wire pad1_o,
	output wire pad1_oe,
	output wire osc_enable,
	output wire bus_timeout_en,
	output wire ext_addr_mode,
	output wire [1:0] slave_addr_lsb,
	input wire conv_bit_i,
	output wire conv_sample,
	output wire [1:0] conv_bias_sel,
	output wire [1:0] amp_bias_sel,
	output wire [2:0] conv_bias_level,
	output wire [2:0] amp_bias_level,
	output wire [3:0] stage_enable,
	output wire [1:0] sample_freq_sel,
	output wire [1:0] stage2_gain,
	output wire [3:0] stage2_offset,
	output wire stage1_gain,
	output wire [6:0] stage3_gain,
	output wire [6:0] stage3_offset,
	output wire [4:0] input_mux_sel,
	output wire ref_sel,
	output wire input_chop,
	output wire ref_chop,
	output wire pump_on,
	output wire ref_out_on_pad0,
	output wire ext_ref_on_pad1,
	output wire busy
);

	localparam ST_IDLE = 2'd0;
	localparam ST_SAMPLE = 2'd1;
	localparam ST_ELEM_END = 2'd2;
	// Tick period cut to the divider width on purpose
	localparam [15:0] SAMPLE_LEN = SAMPLE_CYC;

	reg [7:0] osc_r, padout_r, timeout_r, extaddr_r, conv_r, bias_r, rate_r;
	reg [7:0] gain_r, offs_r, mux_r, mode_r;
	reg [15:0] result_r, acc_r;
	reg [1:0] state_r;
	reg [10:0] osr_cnt_r;
	reg [3:0] elem_cnt_r;
	reg [15:0] div_cnt_r;
	reg in_chop_r, ref_chop_r, ref_half_r;
	reg [2:0] p0_sync_r, p1_sync_r;
	reg pad0_lvl_r, pad1_lvl_r, unlock_r;
	wire start_req;
	wire tick;
	wire [10:0] osr_len;
	wire [3:0] elem_len;

	// Expands a two-bit bias code into a one-hot level: quarter, half, full
	function [2:0] bias_level;
		input [1:0] code;
		begin
			case (code)
				2'b00: bias_level = 3'b001;
				2'b01: bias_level = 3'b010;
				2'b11: bias_level = 3'b100;
				default: bias_level = 3'b100;
			endcase
		end
	endfunction

	// Pad inputs pass three flops; a change counts when stages two and three agree
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			p0_sync_r <= 3'h0;
			p1_sync_r <= 3'h0;
			pad0_lvl_r <= 1'b0;
			pad1_lvl_r <= 1'b0;
		end else begin
			p0_sync_r <= {p0_sync_r[1:0], pad0_i};
			p1_sync_r <= {p1_sync_r[1:0], pad1_i};
			if (p0_sync_r[1] == p0_sync_r[2])
				pad0_lvl_r <= p0_sync_r[2];
			if (p1_sync_r[1] == p1_sync_r[2])
				pad1_lvl_r <= p1_sync_r[2];
		end
	end

	// A start comes from the start bit or the default-load bit
	assign start_req = reg_wr && (
		(reg_addr == `SACR_ADDR_CONV && reg_wdata[`SACR_START_BIT]) || // RULE8
		(reg_addr == `SACR_ADDR_MUX && reg_wdata[`SACR_DEF_BIT])); // RULE15

	// Register writes, default load and the self-clearing start bit
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			osc_r <= `SACR_RST_OSC; // RULE1
			padout_r <= `SACR_RST_PADOUT; // RULE2
			timeout_r <= `SACR_RST_TIMEOUT; // RULE5
			extaddr_r <= `SACR_RST_EXTADDR;
			unlock_r <= 1'b0;
			conv_r <= `SACR_RST_CONV; // RULE9 RULE11
			bias_r <= `SACR_RST_BIAS; // RULE13
			rate_r <= `SACR_RST_RATE; // RULE14
			gain_r <= `SACR_RST_GAIN;
			offs_r <= `SACR_RST_OFFS;
			mux_r <= `SACR_RST_MUX;
			mode_r <= `SACR_RST_MODE; // RULE20
		end else begin
			if (state_r == ST_IDLE && !start_req)
				conv_r[`SACR_START_BIT] <= 1'b0;
			if (reg_wr) begin
				case (reg_addr)
					`SACR_ADDR_OSC: osc_r[0] <= reg_wdata[`SACR_OSC_EN_BIT];
					`SACR_ADDR_PADOUT: padout_r[5:0] <= reg_wdata[5:0];
					`SACR_ADDR_TIMEOUT: timeout_r <= reg_wdata;
					`SACR_ADDR_EXTADDR: begin
						extaddr_r <= reg_wdata;
						if (reg_wdata == `SACR_UNLOCK_CODE) // RULE6
							unlock_r <= 1'b1;
					end
					`SACR_ADDR_CONV: conv_r[7:1] <= reg_wdata[7:1];
					`SACR_ADDR_BIAS: bias_r <= reg_wdata;
					`SACR_ADDR_RATE: rate_r <= reg_wdata;
					`SACR_ADDR_GAIN: gain_r <= reg_wdata; // RULE29
					`SACR_ADDR_OFFS: offs_r <= reg_wdata;
					`SACR_ADDR_MUX: begin
						mux_r[5:0] <= reg_wdata[5:0]; // RULE16 RULE17
						if (reg_wdata[`SACR_DEF_BIT]) begin // RULE15
							bias_r <= `SACR_DEF_BIAS;
							rate_r <= `SACR_DEF_RATE;
							gain_r <= `SACR_DEF_GAIN;
							offs_r <= `SACR_DEF_OFFS;
						end
					end
					`SACR_ADDR_MODE: mode_r[5:0] <= reg_wdata[5:0];
					default: ;
				endcase
			end
		end
	end

	// Register read mux; unmapped addresses read zero
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin // RULE26
			case (reg_addr)
				`SACR_ADDR_OSC: reg_rdata <= osc_r;
				`SACR_ADDR_PADOUT: reg_rdata <= padout_r;
				`SACR_ADDR_PADIN: reg_rdata <= {6'h00, pad1_lvl_r, pad0_lvl_r}; // RULE28
				`SACR_ADDR_TIMEOUT: reg_rdata <= {timeout_r[7:6], 1'b0, timeout_r[4:0]}; // RULE5
				`SACR_ADDR_EXTADDR: reg_rdata <= extaddr_r;
				`SACR_ADDR_RES_LO: reg_rdata <= result_r[7:0]; // RULE7
				`SACR_ADDR_RES_HI: reg_rdata <= result_r[15:8]; // RULE7
				`SACR_ADDR_CONV: reg_rdata <= {conv_r[7:1], 1'b0};
				`SACR_ADDR_BIAS: reg_rdata <= bias_r;
				`SACR_ADDR_RATE: reg_rdata <= rate_r;
				`SACR_ADDR_GAIN: reg_rdata <= gain_r;
				`SACR_ADDR_OFFS: reg_rdata <= offs_r;
				`SACR_ADDR_MUX: reg_rdata <= {busy, 1'b0, mux_r[5:0]}; // RULE27
				`SACR_ADDR_MODE: reg_rdata <= mode_r;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Sample tick divider stands in for the converter sampling clock
	always @(posedge clk or posedge rst) begin
		if (rst)
			div_cnt_r <= 16'h0000;
		else if (state_r == ST_IDLE || tick)
			div_cnt_r <= 16'h0000;
		else
			div_cnt_r <= div_cnt_r + 16'h0001;
	end
	assign tick = (div_cnt_r == SAMPLE_LEN - 16'h0001) && osc_enable;

	// Shift amount widened so that fields 5 to 7 do not wrap
	assign osr_len = 11'h001 << ({1'b0, conv_r[4:2]} + 4'h3); // RULE11
	assign elem_len = 4'h1 << conv_r[6:5]; // RULE9

	// Conversion sequencer: elementary conversions of OSR samples each
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			osr_cnt_r <= 11'h000;
			elem_cnt_r <= 4'h0;
			acc_r <= 16'h0000;
			result_r <= 16'h0000;
			in_chop_r <= 1'b0;
			ref_chop_r <= 1'b0;
			ref_half_r <= 1'b0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (start_req || conv_r[`SACR_CONT_BIT]) begin // RULE8 RULE12
						state_r <= ST_SAMPLE;
						osr_cnt_r <= 11'h000;
						elem_cnt_r <= 4'h0;
						acc_r <= 16'h0000;
						in_chop_r <= 1'b0;
						ref_half_r <= 1'b0;
						ref_chop_r <= mode_r[4];
					end
				end
				ST_SAMPLE: begin
					if (tick) begin
						if (conv_bit_i ^ in_chop_r)
							acc_r <= acc_r + 16'h0001;
						if (osr_cnt_r == osr_len - 11'h001)
							state_r <= ST_ELEM_END;
						else
							osr_cnt_r <= osr_cnt_r + 11'h001;
					end
				end
				ST_ELEM_END: begin
					osr_cnt_r <= 11'h000;
					in_chop_r <= ~in_chop_r; // RULE10
					ref_half_r <= ~ref_half_r;
					case (mode_r[5:4]) // RULE18
						2'b00: ref_chop_r <= 1'b0;
						2'b01: ref_chop_r <= 1'b1;
						2'b10: ref_chop_r <= ~ref_chop_r;
						default: if (ref_half_r) ref_chop_r <= ~ref_chop_r;
					endcase
					if (elem_cnt_r == elem_len - 4'h1) begin
						result_r <= acc_r;
						state_r <= ST_IDLE;
					end else begin
						elem_cnt_r <= elem_cnt_r + 4'h1;
						state_r <= ST_SAMPLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	assign busy = (state_r != ST_IDLE); // RULE27

	// Pad drivers and address source
	assign pad1_oe = padout_r[`SACR_PAD1_DIR_BIT] && !mode_r[`SACR_EXT_REF_BIT]; // RULE2 RULE3
	assign pad1_o = padout_r[`SACR_PAD1_OUT_BIT]; // RULE3
	assign pad0_oe = padout_r[`SACR_PAD0_DIR_BIT] && !mode_r[`SACR_REF_OUT_BIT]; // RULE2 RULE4
	assign pad0_o = padout_r[`SACR_PAD0_OUT_BIT]; // RULE4
	assign ext_addr_mode = unlock_r; // RULE6
	assign slave_addr_lsb = unlock_r ? {pad1_lvl_r, pad0_lvl_r} : 2'b00; // RULE6

	// Control codes to the analog chain
	assign osc_enable = osc_r[`SACR_OSC_EN_BIT]; // RULE1
	assign bus_timeout_en = timeout_r[`SACR_TIMEOUT_BIT]; // RULE5
	assign conv_sample = tick && state_r == ST_SAMPLE;
	assign conv_bias_sel = bias_r[7:6]; // RULE13
	assign amp_bias_sel = bias_r[5:4]; // RULE13
	assign conv_bias_level = bias_level(bias_r[7:6]); // RULE23
	assign amp_bias_level = bias_level(bias_r[5:4]); // RULE23
	assign stage_enable = bias_r[3:0]; // RULE24
	assign sample_freq_sel = rate_r[7:6]; // RULE14
	assign stage2_gain = rate_r[5:4]; // RULE29
	assign stage2_offset = rate_r[3:0]; // RULE29
	assign stage1_gain = gain_r[7]; // RULE29
	assign stage3_gain = gain_r[6:0]; // RULE29
	assign stage3_offset = offs_r[6:0]; // RULE29
	assign input_mux_sel = mux_r[5:1]; // RULE16
	assign ref_sel = mux_r[0]; // RULE17
	assign input_chop = in_chop_r; // RULE10
	assign ref_chop = ref_chop_r; // RULE18
	assign pump_on = mode_r[`SACR_FORCE_ON_BIT] || !mode_r[`SACR_FORCE_OFF_BIT]; // RULE19 RULE20
	assign ref_out_on_pad0 = mode_r[`SACR_REF_OUT_BIT]; // RULE21
	assign ext_ref_on_pad1 = mode_r[`SACR_EXT_REF_BIT]; // RULE22

endmodule
`default_nettype wire

// >>> verification/sacr_master.sv
// Register-access master standing in for the two-wire bus controller
`timescale 1ns/100ps
`default_nettype none
module sacr_master (
	input wire logic clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	// Bus idle from time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// One strobe cycle per byte, held across the sampling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask
	// Read data is registered, so it is taken one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// >>> verification/sacr_checker.sv
// Port-level assertions of the sensor register bank
`timescale 1ns/100ps
`default_nettype none
module sacr_checker #(parameter SAMPLE_CYC = 8) (
	input wire logic clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic osc_enable,
	input wire logic bus_timeout_en,
	input wire logic ext_addr_mode,
	input wire logic [1:0] slave_addr_lsb,
	input wire logic pad0_oe,
	input wire logic pad1_oe,
	input wire logic ref_out_on_pad0,
	input wire logic ext_ref_on_pad1,
	input wire logic pump_on,
	input wire logic busy,
	input wire logic [1:0] conv_bias_sel,
	input wire logic [2:0] conv_bias_level,
	input wire logic [3:0] stage_enable,
	input wire logic conv_sample
);
	logic [7:0] wd_r;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Write data one cycle back
	always @(posedge clk) begin
		wd_r <= reg_wdata;
	end
	a_osc_write_follow: assert property (
		reg_wr && reg_addr == 8'h30 |=> osc_enable == wd_r[0])
		else $error("osc enable does not follow write");
	a_timeout_write_follow: assert property (
		reg_wr && reg_addr == 8'h42 |=> bus_timeout_en == wd_r[5])
		else $error("timeout enable does not follow write");
	a_unlock_sets_mode: assert property (
		reg_wr && reg_addr == 8'h43 && reg_wdata == 8'h96 |=> ext_addr_mode)
		else $error("unlock code ignored");
	a_locked_addr_zero: assert property (!ext_addr_mode |-> slave_addr_lsb == 2'b00)
		else $error("address bits move while locked");
	a_pad1_ref_release: assert property (ext_ref_on_pad1 |-> !pad1_oe)
		else $error("pad one driven with external reference");
	a_pad0_ref_release: assert property (ref_out_on_pad0 |-> !pad0_oe)
		else $error("pad zero driven with reference output");
	a_pump_force_order: assert property (
		reg_wr && reg_addr == 8'h70 |=> pump_on == (wd_r[3] | !wd_r[2]))
		else $error("charge pump force priority wrong");
	a_start_sets_busy: assert property (
		reg_wr && reg_addr == 8'h52 && reg_wdata[7] && osc_enable && !busy |=> busy)
		else $error("start does not raise busy");
	a_bias_level_map: assert property (
		conv_bias_level == (conv_bias_sel == 2'b00 ? 3'b001 :
		conv_bias_sel == 2'b01 ? 3'b010 : 3'b100))
		else $error("bias level decode wrong");
	a_stage_enable_write: assert property (
		reg_wr && reg_addr == 8'h53 |=> stage_enable == wd_r[3:0])
		else $error("stage enables do not follow write");
	c_conv_start: cover property ($rose(busy));
	c_unlocked: cover property ($rose(ext_addr_mode));
	c_sample_tick: cover property (conv_sample);
endmodule
bind sacr_sensor_regs sacr_checker #(.SAMPLE_CYC(SAMPLE_CYC)) chk (.clk(clk), .rst(rst),
	.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .osc_enable(osc_enable),
	.bus_timeout_en(bus_timeout_en), .ext_addr_mode(ext_addr_mode),
	.slave_addr_lsb(slave_addr_lsb), .pad0_oe(pad0_oe), .pad1_oe(pad1_oe),
	.ref_out_on_pad0(ref_out_on_pad0), .ext_ref_on_pad1(ext_ref_on_pad1), .pump_on(pump_on),
	.busy(busy), .conv_bias_sel(conv_bias_sel), .conv_bias_level(conv_bias_level),
	.stage_enable(stage_enable), .conv_sample(conv_sample));
`default_nettype wire

// >>> verification/sensor_adc_control_registers_bench.sv
// Self-checking bench of the sensor register bank
`timescale 1ns/100ps
`default_nettype none
module sensor_adc_control_registers_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic conv_bit_i = 1'b1;
	logic [1:0] ext_pad = 2'b00;
	int mismatches = 0;
	int n_checks = 0;
	int samples = 0;
	int cycles = 0;
	wire reg_wr, reg_rd, pad0_o, pad0_oe, pad1_o, pad1_oe, osc_enable, bus_timeout_en;
	wire ext_addr_mode, conv_sample, pump_on, busy, ref_chop;
	wire [7:0] reg_addr, reg_wdata, reg_rdata;
	wire [1:0] slave_addr_lsb;
	wire [2:0] conv_bias_level, amp_bias_level;
	wire [3:0] stage_enable;
	// Pad wire: the block when driving, else the external resistor
	wire p0 = pad0_oe ? pad0_o : ext_pad[0];
	wire p1 = pad1_oe ? pad1_o : ext_pad[1];
	// Clock, cycle count, timeout and sample tick count
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (conv_sample === 1'b1) samples++;
		if (cycles == 20000) begin
			mismatches++;
			end_sim();
		end
	end
	sacr_master m (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	sacr_sensor_regs #(.SAMPLE_CYC(1)) dut (.clk(clk), .rst(rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.pad0_i(p0), .pad1_i(p1), .pad0_o(pad0_o), .pad0_oe(pad0_oe), .pad1_o(pad1_o),
		.pad1_oe(pad1_oe), .osc_enable(osc_enable), .bus_timeout_en(bus_timeout_en),
		.ext_addr_mode(ext_addr_mode), .slave_addr_lsb(slave_addr_lsb),
		.conv_bit_i(conv_bit_i), .conv_sample(conv_sample), .conv_bias_sel(),
		.amp_bias_sel(), .conv_bias_level(conv_bias_level), .amp_bias_level(amp_bias_level),
		.stage_enable(stage_enable), .sample_freq_sel(), .stage2_gain(), .stage2_offset(),
		.stage1_gain(), .stage3_gain(), .stage3_offset(), .input_mux_sel(), .ref_sel(),
		.input_chop(), .ref_chop(ref_chop), .pump_on(pump_on), .ref_out_on_pad0(),
		.ext_ref_on_pad1(), .busy(busy));
	// Compare and count
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Read a register and compare
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		m.rd(a, d);
		chk($sformatf("reg %h", a), d, exp);
	endtask
	// Wait for the sequencer to go idle, bounded
	task automatic wait_idle;
		for (int i = 0; i < 500 && busy !== 1'b0; i++) @(negedge clk);
		chk("busy", {7'h00, busy}, 8'h00);
	endtask
	// Reset values of every register except the pad input register, and an unmapped address
	task automatic t_reset;
		logic [7:0] a [14] = '{8'h30, 8'h40, 8'h42, 8'h43, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54,
			8'h55, 8'h56, 8'h57, 8'h70, 8'h60};
		logic [7:0] e [14] = '{8'h01, 8'hF0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h28, 8'hF0, 8'h00,
			8'h0C, 8'h00, 8'h00, 8'h84, 8'h00};
		for (int i = 0; i < 14; i++)
			rchk(a[i], e[i]);
	endtask
	// Pad direction, input levels and release by reference functions
	task automatic t_pads;
		logic [7:0] mv [4] = '{8'h85, 8'h86, 8'h8C, 8'h84};
		logic [7:0] ev [4] = '{8'h01, 8'h02, 8'h07, 8'h03};
		m.wr(8'h40, 8'hC2);
		ext_pad = 2'b10;
		repeat (4) @(negedge clk);
		chk("pad oe", {6'h00, pad1_oe, pad0_oe}, 8'h00);
		rchk(8'h41, 8'h02);
		m.wr(8'h40, 8'hF3);
		chk("pads", {6'h00, p1, p0}, 8'h03);
		for (int i = 0; i < 4; i++) begin
			m.wr(8'h70, mv[i]);
			chk("pump oe", {5'h00, pump_on, pad1_oe, pad0_oe},
				ev[i]);
		end
	endtask
	// Oscillator, timeout and address unlock
	task automatic t_misc;
		m.wr(8'h30, 8'h00);
		chk("osc", {7'h00, osc_enable}, 8'h00);
		m.wr(8'h30, 8'h01);
		m.wr(8'h42, 8'h20);
		chk("timeout", {7'h00, bus_timeout_en}, 8'h01);
		rchk(8'h42, 8'h00);
		m.wr(8'h40, 8'hC0);
		ext_pad = 2'b01;
		m.wr(8'h43, 8'h95);
		repeat (4) @(negedge clk);
		chk("addr lsb", {6'h00, slave_addr_lsb}, 8'h00);
		m.wr(8'h43, 8'h96);
		repeat (4) @(negedge clk);
		chk("addr lsb", {6'h00, slave_addr_lsb}, 8'h01);
	endtask
	// Two elementary conversions of eight samples with chopping
	task automatic t_conv;
		samples = 0;
		m.wr(8'h52, 8'hA0);
		rchk(8'h57, 8'h80);
		wait_idle();
		chk("samples", samples[7:0], 8'h10);
		rchk(8'h50, 8'h08);
		rchk(8'h51, 8'h00);
		rchk(8'h52, 8'h20);
	endtask
	// Default load, bias decode and stage enables
	task automatic t_def;
		m.wr(8'h53, 8'h50);
		chk("bias", {2'b00, conv_bias_level, amp_bias_level}, 8'h12);
		chk("stages", {4'h0, stage_enable}, 8'h00);
		m.wr(8'h57, 8'h40);
		chk("busy", {7'h00, busy}, 8'h01);
		wait_idle();
		rchk(8'h53, 8'hFF);
		rchk(8'h55, 8'h0C);
	endtask
	// Continuous mode with forced reference chop, then field readback
	task automatic t_cont;
		m.wr(8'h70, 8'h94);
		samples = 0;
		m.wr(8'h52, 8'h02);
		repeat (40) @(negedge clk);
		chk("repeat", {7'h00, samples > 8}, 8'h01);
		chk("ref chop", {7'h00, ref_chop}, 8'h01);
		m.wr(8'h52, 8'h00);
		wait_idle();
		rchk(8'h50, 8'h08);
		m.wr(8'h57, 8'h2B);
		rchk(8'h57, 8'h2B);
		m.wr(8'h55, 8'h8C);
		rchk(8'h55, 8'h8C);
	endtask
	// Closing report and verdict
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_pads();
		t_misc();
		t_conv();
		t_def();
		t_cont();
		end_sim();
	end
endmodule
`default_nettype wire
